// ### cld_pkg.sv
`default_nettype none
package cld_pkg;
   // Register offsets
   localparam logic [7:0] CLD_ADDR_CTRL = 8'h2C;
   localparam logic [7:0] CLD_ADDR_TO1 = 8'h2D;
   localparam logic [7:0] CLD_ADDR_TO2 = 8'h2E;
   localparam logic [7:0] CLD_ADDR_RECOV = 8'h32;
   // Reset values
   localparam logic [7:0] CLD_RST_CTRL = 8'h00;
   localparam logic [7:0] CLD_RST_TO1 = 8'h17;
   localparam logic [7:0] CLD_RST_TO2 = 8'h00;
   localparam logic [7:0] CLD_RST_RECOV = 8'h00;
   // Control, timeout and recovery register fields
   localparam int CLD_BIT_EN2 = 0;
   localparam int CLD_BIT_EN1 = 1;
   localparam int CLD_POS_SRC2 = 2;
   localparam int CLD_BIT_SRC1 = 4;
   localparam int CLD_BIT_MUTE = 5;
   localparam int CLD_POS_TO = 0;
   localparam int CLD_POS_RAMP = 6;
   localparam int CLD_BIT_NOREC1 = 0;
   localparam int CLD_BIT_NOREC2 = 1;
   // Clock and timing
   localparam int CLD_CLK_MHZ = 125;
   localparam real CLD_TO_MS [8] = '{2.73, 22.0, 44.0, 87.0, 174.0, 350.0, 700.0, 1400.0};
   localparam real CLD_RAMP_US_PER_DB [4] = '{15.0, 30.0, 60.0, 120.0};
   localparam int CLD_CNT_W = 28;
   localparam int CLD_RAMP_W = 16;
   localparam int CLD_GAIN_MAX = 8'hFF;
   typedef enum logic [1:0] {
      CLD_IDLE = 2'b00,
      CLD_WATCH = 2'b01,
      CLD_FAULT = 2'b11
   } cld_state_t;
endpackage : cld_pkg
`default_nettype wire

// ### cld_monitor.sv
`default_nettype none
// One absence-timeout watcher for a pre-synchronised clock level
module cld_monitor
   import cld_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic enable,
   input wire logic clk_level,
   input wire logic [CLD_CNT_W-1:0] limit,
   input wire logic no_recover,
   output logic fault
);
   cld_state_t state;
   cld_state_t next_state;
   logic [CLD_CNT_W-1:0] count;
   logic [CLD_CNT_W-1:0] next_count;
   logic last;
   logic edge_seen;

   assign edge_seen = clk_level ^ last;
   assign fault = (state == CLD_FAULT);

   // Timer restarts on any edge; fault holds until disable, or until an edge when recovery allowed
   always_comb begin
      next_state = state;
      next_count = count;
      unique case (state)
         CLD_IDLE: begin
            next_count = '0;
            if (enable) begin
               next_state = CLD_WATCH;
            end
         end
         CLD_WATCH: begin
            if (!enable) begin
               next_state = CLD_IDLE;
            end else if (edge_seen) begin
               next_count = '0;
            end else if (count >= limit) begin
               next_state = CLD_FAULT;
            end else begin
               next_count = count + 1'b1;
            end
         end
         CLD_FAULT: begin
            next_count = '0;
            if (!enable) begin
               next_state = CLD_IDLE;
            end else if (edge_seen && !no_recover) begin
               next_state = CLD_WATCH;
            end
         end
         default: next_state = CLD_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state <= CLD_IDLE;
         count <= '0;
         last <= 1'b0;
      end else begin
         state <= next_state;
         count <= next_count;
         last <= clk_level;
      end
   end
endmodule : cld_monitor
`default_nettype wire

// ### cld_top.sv
`default_nettype none
// Behaviour
// - Bit 1 of control enables the first monitor; zero keeps it idle.
// - Bit 0 of control enables the second monitor; zero keeps it idle.
// - Bit 4 picks first or second serial port clock for monitor one.
// - Bits 3-2 pick DAC, ADC or PLL clock; code 3 reserved.
// - Monitor one error soft-mutes, hardware or DSP sequence by bit 5.
// - Monitor one timeout 2.73 ms to 1.4 s; field resets to 7.
// - Monitor two timeout uses same ladder; field resets to 0.
// - Monitor two error ramps DAC gain down at 15-120 us per dB.
// - Recovery-disable bit per monitor blocks automatic recovery after error.
module cld_top
   import cld_pkg::*;
#(
   parameter int TO_SCALE = 1
)
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic first_audio_serial_port_clk,
   input wire logic second_audio_serial_port_clk,
   input wire logic dac_mod_clk,
   input wire logic adc_mod_clk,
   input wire logic pll_clk,
   output logic power_error_signal,
   output logic shutdown,
   output logic hw_mute,
   output logic dsp_mute,
   output logic [7:0] dac_gain_atten,
   output logic [7:0] status
);
   logic [7:0] ctrl;
   logic [7:0] to1;
   logic [7:0] to2;
   logic [7:0] recov;
   logic [7:0] next_ctrl;
   logic [7:0] next_to1;
   logic [7:0] next_to2;
   logic [7:0] next_recov;
   logic [7:0] next_rdata;
   logic next_error;
   logic next_hw_mute;
   logic next_dsp_mute;
   logic [7:0] next_status;
   logic [4:0] sync1;
   logic [4:0] sync2;
   logic [4:0] raw;
   logic sel1;
   logic sel2;
   logic fault1;
   logic fault2;
   logic [CLD_CNT_W-1:0] lim1;
   logic [CLD_CNT_W-1:0] lim2;
   logic [CLD_RAMP_W-1:0] ramp_cnt;
   logic [CLD_RAMP_W-1:0] next_ramp_cnt;
   logic [CLD_RAMP_W-1:0] ramp_lim;
   logic [7:0] next_atten;

   // Timeout ladder in cycles; scale lets a bench shorten it
   function automatic logic [CLD_CNT_W-1:0] cld_limit(input logic [2:0] code);
      int cyc;
      cyc = int'(CLD_TO_MS[code] * 1000.0 * CLD_CLK_MHZ) / TO_SCALE;
      if (cyc < 1) begin
         cyc = 1;
      end
      return CLD_CNT_W'(cyc);
   endfunction : cld_limit

   // Cycles per dB of gain ramp-down
   function automatic logic [CLD_RAMP_W-1:0] cld_ramp(input logic [1:0] code);
      return CLD_RAMP_W'(int'(CLD_RAMP_US_PER_DB[code] * CLD_CLK_MHZ));
   endfunction : cld_ramp

   // Two-flop synchronisers for every outside clock
   assign raw = {pll_clk, adc_mod_clk, dac_mod_clk,
                 second_audio_serial_port_clk, first_audio_serial_port_clk};
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= raw;
         sync2 <= sync1;
      end
   end

   assign sel1 = ctrl[CLD_BIT_SRC1] ? sync2[1] : sync2[0];
   // internal clock choice; reserved code watches nothing
   always_comb begin
      unique case (ctrl[CLD_POS_SRC2+:2])
         2'd0: sel2 = sync2[2];
         2'd1: sel2 = sync2[3];
         2'd2: sel2 = sync2[4];
         default: sel2 = 1'b0;
      endcase
   end

   assign lim1 = cld_limit(to1[CLD_POS_TO+:3]);
   assign lim2 = cld_limit(to2[CLD_POS_TO+:3]);
   assign ramp_lim = cld_ramp(to2[CLD_POS_RAMP+:2]);

   cld_monitor i_cld_monitor_1 (
      .clock(clock),
      .rst_n(rst_n),
      .enable(ctrl[CLD_BIT_EN1]),
      .clk_level(sel1),
      .limit(lim1),
      .no_recover(recov[CLD_BIT_NOREC1]),
      .fault(fault1)
   );
   cld_monitor i_cld_monitor_2 (
      .clock(clock),
      .rst_n(rst_n),
      .enable(ctrl[CLD_BIT_EN2] && ctrl[CLD_POS_SRC2+:2] != 2'd3),
      .clk_level(sel2),
      .limit(lim2),
      .no_recover(recov[CLD_BIT_NOREC2]),
      .fault(fault2)
   );

   // Read data holds between reads; unmapped reads give zero
   always_comb begin
      next_rdata = reg_rdata;
      if (reg_rd) begin
         unique case (reg_addr)
            CLD_ADDR_CTRL: next_rdata = ctrl;
            CLD_ADDR_TO1: next_rdata = to1;
            CLD_ADDR_TO2: next_rdata = to2;
            CLD_ADDR_RECOV: next_rdata = recov;
            default: next_rdata = 8'h00;
         endcase
      end
   end

   // Writes keep reserved bits so software reads back what it wrote;
   // an unmapped write simply falls away
   always_comb begin
      next_ctrl = ctrl;
      next_to1 = to1;
      next_to2 = to2;
      next_recov = recov;
      if (reg_wr) begin
         unique case (reg_addr)
            CLD_ADDR_CTRL: next_ctrl = reg_wdata;
            CLD_ADDR_TO1: next_to1 = reg_wdata;
            CLD_ADDR_TO2: next_to2 = reg_wdata;
            CLD_ADDR_RECOV: next_recov = reg_wdata;
            default: ;
         endcase
      end
   end

   // Fault outputs; one flop of delay keeps every pin glitch free
   always_comb begin
      next_error = fault1 | fault2;
      next_hw_mute = fault1 & ~ctrl[CLD_BIT_MUTE];
      next_dsp_mute = fault1 & ctrl[CLD_BIT_MUTE];
      next_status = {6'h00, fault2, fault1};
   end

   // gain ramp, one dB per programmed interval while error lasts
   always_comb begin
      next_ramp_cnt = ramp_cnt;
      next_atten = dac_gain_atten;
      if (!fault2) begin
         next_ramp_cnt = '0;
         next_atten = 8'h00;
      end else if (ramp_cnt >= ramp_lim - 1'b1) begin
         next_ramp_cnt = '0;
         if (dac_gain_atten != 8'(CLD_GAIN_MAX)) begin
            next_atten = dac_gain_atten + 8'h01;
         end
      end else begin
         next_ramp_cnt = ramp_cnt + 1'b1;
      end
   end

   // Registers and flopped outputs
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ctrl <= CLD_RST_CTRL;
         to1 <= CLD_RST_TO1;
         to2 <= CLD_RST_TO2;
         recov <= CLD_RST_RECOV;
         reg_rdata <= 8'h00;
         ramp_cnt <= '0;
         dac_gain_atten <= 8'h00;
         power_error_signal <= 1'b0;
         shutdown <= 1'b0;
         hw_mute <= 1'b0;
         dsp_mute <= 1'b0;
         status <= 8'h00;
      end else begin
         ctrl <= next_ctrl;
         to1 <= next_to1;
         to2 <= next_to2;
         recov <= next_recov;
         reg_rdata <= next_rdata;
         ramp_cnt <= next_ramp_cnt;
         dac_gain_atten <= next_atten;
         power_error_signal <= next_error;
         shutdown <= next_error;
         hw_mute <= next_hw_mute;
         dsp_mute <= next_dsp_mute;
         status <= next_status;
      end
   end
endmodule : cld_top
`default_nettype wire

// ### cld_clk_src.sv
`default_nettype none
// Host clocks; a stopped line rests low
module cld_clk_src (
   input wire logic [4:0] run,
   output logic [4:0] ck
);
   timeunit 1ns;
   timeprecision 100ps;
   // One shared 125 ns rate keeps the model small
   initial begin
      ck = 5'h00;
      forever #62.5 ck = run & ~ck;
   end
endmodule : cld_clk_src
`default_nettype wire

// ### cld_chk_monitor.sv
`default_nettype none
// Port checks on the loss detector
module cld_chk_monitor (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_rdata,
   input wire logic power_error_signal,
   input wire logic shutdown,
   input wire logic hw_mute,
   input wire logic dsp_mute,
   input wire logic [7:0] dac_gain_atten,
   input wire logic [7:0] status
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   property p_sd; power_error_signal == shutdown; endproperty
   a_sd: assert property (p_sd) else $error("shutdown differs");
   property p_pe; power_error_signal == (status[0] | status[1]); endproperty
   a_pe: assert property (p_pe) else $error("power error differs");
   property p_mu; status[0] == (hw_mute | dsp_mute); endproperty
   a_mu: assert property (p_mu) else $error("mute differs");
   property p_hw; !(hw_mute && dsp_mute); endproperty
   a_hw: assert property (p_hw) else $error("both mutes");
   property p_gz; !status[1] ##1 !status[1] |-> dac_gain_atten == 8'h00; endproperty
   a_gz: assert property (p_gz) else $error("gain not zero");
   property p_gs; status[1] ##1 status[1] |-> dac_gain_atten - $past(dac_gain_atten) <= 8'h01;
   endproperty
   a_gs: assert property (p_gs) else $error("gain step");
   property p_rh; !reg_rd |=> $stable(reg_rdata); endproperty
   a_rh: assert property (p_rh) else $error("read data moved");
   property p_ur; reg_rd && reg_addr == 8'h30 |=> reg_rdata == 8'h00; endproperty
   a_ur: assert property (p_ur) else $error("unmapped read");
endmodule : cld_chk_monitor
bind cld_top cld_chk_monitor i_cld_chk_monitor (.clock, .rst_n, .reg_rd, .reg_addr,
   .reg_rdata, .power_error_signal, .shutdown, .hw_mute, .dsp_mute, .dac_gain_atten, .status);
`default_nettype wire

// ### test_clock_loss_detector.sv
`default_nettype none
// Register calls and clock stops, checked at the fault outputs
module test_clock_loss_detector
   import cld_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock, rst_n, reg_wr, reg_rd, power_error_signal, shutdown, hw_mute, dsp_mute;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, dac_gain_atten, status;
   logic [4:0] run, ck;
   int n_fail = 0;
   int tests_run = 0;
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin n_fail++; \
   $display("BAD %s exp %h got %h", n, e, s); end end
   cld_top #(.TO_SCALE(1000)) i_cld_top (.clock, .rst_n, .reg_wr, .reg_rd, .reg_addr,
      .reg_wdata, .reg_rdata, .first_audio_serial_port_clk(ck[0]),
      .second_audio_serial_port_clk(ck[1]), .dac_mod_clk(ck[2]), .adc_mod_clk(ck[3]),
      .pll_clk(ck[4]), .power_error_signal, .shutdown, .hw_mute, .dsp_mute,
      .dac_gain_atten, .status);
   cld_clk_src i_cld_clk_src (.run, .ck);
   // 8 ns system clock
   initial begin
      clock = 0;
      forever #4 clock = ~clock;
   end
   task automatic final_report;
      $display("checks %0d failures %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : final_report
   // Inputs move 1 ns after the edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : cyc
   // Strobe drops for a cycle so calls never collide
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
      cyc(1);
      reg_wr = 0;
      cyc(1);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      {reg_rd, reg_addr} = {1'b1, a};
      cyc(1);
      `CHK("rdata", e, reg_rdata)
      reg_rd = 0;
      cyc(1);
   endtask : rd
   task automatic wpe(input logic e, input int n);
      for (int i = 0; i < n && power_error_signal !== e; i++)
         cyc(1);
      `CHK("power_error", e, power_error_signal)
   endtask : wpe
   // Main sequence
   initial begin
      {reg_wr, reg_rd, reg_addr, reg_wdata, run, rst_n} = '0;
      cyc(10);
      rst_n = 1;
      rd(CLD_ADDR_CTRL, 8'h00);
      rd(CLD_ADDR_TO1, 8'h17);
      rd(CLD_ADDR_TO2, 8'h00);
      rd(CLD_ADDR_RECOV, 8'h00);
      rd(8'h30, 8'h00);
      wr(CLD_ADDR_TO1, 8'hF8);
      rd(CLD_ADDR_TO1, 8'hF8);
      $display("registers done");
      cyc(600);
      `CHK("idle", 1'b0, power_error_signal)
      wr(CLD_ADDR_CTRL, 8'h02);
      cyc(300);
      `CHK("early", 1'b0, power_error_signal)
      wpe(1, 100);
      `CHK("shutdown", 1'b1, shutdown)
      `CHK("status", 8'h01, status)
      `CHK("hw_mute", 1'b1, hw_mute)
      run = 5'h01;
      wpe(0, 100);
      cyc(600);
      `CHK("alive", 1'b0, power_error_signal)
      wr(CLD_ADDR_CTRL, 8'h32);
      wpe(1, 500);
      `CHK("dsp_mute", 1'b1, dsp_mute)
      run = 5'h02;
      wpe(0, 100);
      $display("first monitor done");
      // every source code, reserved one idle
      for (int c = 0; c < 4; c++) begin
         run = 5'h04 << c;
         wr(CLD_ADDR_CTRL, {4'h0, c[1:0], 2'b01});
         cyc(600);
         `CHK("source", 1'b0, power_error_signal)
      end
      wr(CLD_ADDR_CTRL, 8'h09);
      wpe(1, 500);
      `CHK("status", 8'h02, status)
      // one dB after 1875 cycles at the fastest rate
      cyc(2500);
      `CHK("ramp", 8'h01, dac_gain_atten)
      wr(CLD_ADDR_RECOV, 8'h02);
      run = 5'h10;
      cyc(200);
      `CHK("no_recover", 1'b1, power_error_signal)
      wr(CLD_ADDR_CTRL, 8'h00);
      wpe(0, 50);
      // timeout code 1 is 2750 cycles, ramp code 1 is 3750 per dB
      wr(CLD_ADDR_TO2, 8'h41);
      run = 5'h00;
      wr(CLD_ADDR_CTRL, 8'h09);
      cyc(2600);
      `CHK("early2", 1'b0, power_error_signal)
      wpe(1, 300);
      cyc(5000);
      `CHK("ramp_slow", 8'h01, dac_gain_atten)
      $display("second monitor done");
      final_report();
   end
   // Hang guard, well past the expected run
   initial begin
      cyc(25000);
      n_fail++;
      final_report();
   end
endmodule : test_clock_loss_detector
`default_nettype wire
